// *** hw/sisp_pkg.sv ***
// Constants and types for the serial in-system programming port
package sisp_pkg;
    // Instruction opcodes, first byte
    localparam logic [7:0] OP_ENABLE_OR_FUSE = 8'hAC;
    localparam logic [7:0] OP_POLL = 8'hF0;
    localparam logic [7:0] OP_LOAD_HI = 8'h48;
    localparam logic [7:0] OP_LOAD_LO = 8'h40;
    localparam logic [7:0] OP_EE_LOAD = 8'hC1;
    localparam logic [7:0] OP_READ_HI = 8'h28;
    localparam logic [7:0] OP_READ_LO = 8'h20;
    localparam logic [7:0] OP_EE_READ = 8'hA0;
    localparam logic [7:0] OP_READ_LOCK_FHI = 8'h58;
    localparam logic [7:0] OP_READ_SIG = 8'h30;
    localparam logic [7:0] OP_READ_FUSE = 8'h50;
    localparam logic [7:0] OP_READ_CAL = 8'h38;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h4C;
    localparam logic [7:0] OP_EE_WRITE = 8'hC0;
    localparam logic [7:0] OP_EE_PAGE_WRITE = 8'hC2;
    // Second byte codes after the 0xAC first byte, plus the 0x08 high-byte read select
    localparam logic [7:0] SUB_ENABLE = 8'h53;
    localparam logic [7:0] SUB_ERASE = 8'h80;
    localparam logic [7:0] SUB_LOCK = 8'hE0;
    localparam logic [7:0] SUB_FUSE_LO = 8'hA0;
    localparam logic [7:0] SUB_FUSE_HI = 8'hA8;
    localparam logic [7:0] SUB_FUSE_EXT = 8'hA4;
    localparam logic [7:0] SEL_HIGH = 8'h08;
    // Memory geometry
    localparam int FLASH_WORDS = 2048;
    localparam int FLASH_AW = 11;
    localparam int PAGE_AW = 5;
    localparam int EE_AW = 6;
    localparam int EE_PAGE_AW = 2;
    localparam logic [7:0] ERASED = 8'hFF;
    // Reset values of the nonvolatile bytes
    localparam logic [7:0] FUSE_LO_RST = 8'h62;
    localparam logic [7:0] FUSE_HI_RST = 8'hDF;
    localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
    localparam logic [7:0] LOCK_RST = 8'hFF;
    localparam logic [7:0] CAL_RST = 8'h80;
    // Arbitrary neutral signature values
    localparam logic [7:0] SIG0 = 8'h5A;
    localparam logic [7:0] SIG1 = 8'h01;
    localparam logic [7:0] SIG2 = 8'h02;
    // Write wait times in microseconds and the system clock
    localparam int CLK_MHZ = 200;
    localparam int FLASH_PAGE_WAIT_US = 4500;
    localparam int EEPROM_WRITE_WAIT_US = 4000;
    localparam int CHIP_ERASE_WAIT_US = 4000;
    localparam int FUSE_WRITE_WAIT_US = 4500;
    localparam int FLASH_PAGE_WAIT_CYC = FLASH_PAGE_WAIT_US * CLK_MHZ;
    localparam int EEPROM_WRITE_WAIT_CYC = EEPROM_WRITE_WAIT_US * CLK_MHZ;
    localparam int CHIP_ERASE_WAIT_CYC = CHIP_ERASE_WAIT_US * CLK_MHZ;
    localparam int FUSE_WRITE_WAIT_CYC = FUSE_WRITE_WAIT_US * CLK_MHZ;
    localparam int BUSY_W = 20;
    // Engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_ERASE = 2'b10
    } sisp_state_e;
endpackage

// *** hw/sisp_port.sv ***
// Serial in-system programming port with flash, EEPROM and fuse storage
`timescale 1ns/1ps
`default_nettype none
module sisp_port #(
    parameter int FLASH_WAIT = sisp_pkg::FLASH_PAGE_WAIT_CYC,
    parameter int EEPROM_WAIT = sisp_pkg::EEPROM_WRITE_WAIT_CYC,
    parameter int ERASE_WAIT = sisp_pkg::CHIP_ERASE_WAIT_CYC,
    parameter int FUSE_WAIT = sisp_pkg::FUSE_WRITE_WAIT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic resetPinN,
    input wire logic serialClk,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutEn,
    output logic progEnabled,
    output logic opPendingFlag
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the first stage feeds only the second
    logic [1:0] sckSync, mosiSync, rstnSync;
    logic sckLast;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sckSync <= 2'h0;
            mosiSync <= 2'h0;
            rstnSync <= 2'h3;
            sckLast <= 1'b0;
        end else begin
            sckSync <= {sckSync[0], serialClk};
            mosiSync <= {mosiSync[0], serialIn};
            rstnSync <= {rstnSync[0], resetPinN};
            sckLast <= sckSync[1];
        end
    end

    wire sck = sckSync[1];
    wire mosi = mosiSync[1];
    // Session lives only while the reset pin is low
    wire inSession = ~rstnSync[1];
    wire sckRise = inSession & sck & ~sckLast;
    wire sckFall = inSession & ~sck & sckLast;

    ////////////////////////////////////////////////////////////////////
    // Shift register and bit counter
    logic [31:0] shiftIn;
    logic [4:0] bitCnt;
    logic [7:0] outByte;
    logic [31:0] next_shiftIn;
    assign next_shiftIn = {shiftIn[30:0], mosi};
    wire lastBit = sckRise & (bitCnt == 5'h1F);
    wire [7:0] b1 = next_shiftIn[31:24];
    wire [7:0] b2 = next_shiftIn[23:16];
    wire [7:0] b3 = next_shiftIn[15:8];
    wire [7:0] b4 = next_shiftIn[7:0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shiftIn <= 32'h0;
            bitCnt <= 5'h0;
        end else if (!inSession) begin
            bitCnt <= 5'h0;
        end else if (sckRise) begin
            shiftIn <= next_shiftIn;
            bitCnt <= bitCnt + 5'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Storage arrays in flip-flops
    logic [15:0] flashMem [sisp_pkg::FLASH_WORDS];
    logic [15:0] pageBuf [2**sisp_pkg::PAGE_AW];
    logic [7:0] eeMem [2**sisp_pkg::EE_AW];
    logic [7:0] eeBuf [2**sisp_pkg::EE_PAGE_AW];
    logic [3:0] eeLoaded;
    logic [7:0] fuseLo, fuseHi, fuseExt, lockBits;
    logic [sisp_pkg::BUSY_W-1:0] busyCnt;
    sisp_pkg::sisp_state_e state;

    wire [sisp_pkg::FLASH_AW-1:0] wordAddr =
        sisp_pkg::FLASH_AW'({b2, b3});
    wire [sisp_pkg::PAGE_AW-1:0] pageIdx = wordAddr[sisp_pkg::PAGE_AW-1:0];
    wire [5:0] pageNum = wordAddr[sisp_pkg::FLASH_AW-1:sisp_pkg::PAGE_AW];
    wire [sisp_pkg::EE_AW-1:0] eeAddr = b3[sisp_pkg::EE_AW-1:0];
    wire [3:0] eePage = b3[sisp_pkg::EE_AW-1:sisp_pkg::EE_PAGE_AW];

    // Command decode, qualified by the last bit and, except for enable, the enable state
    wire isAc = b1 == sisp_pkg::OP_ENABLE_OR_FUSE;
    wire idle = state == sisp_pkg::ST_IDLE;
    // Program and erase gated by enable
    wire cmdOk = lastBit & progEnabled;
    wire doEnable = lastBit & isAc & (b2 == sisp_pkg::SUB_ENABLE);
    wire doErase = cmdOk & idle & isAc & (b2 == sisp_pkg::SUB_ERASE);
    wire doLoadHi = cmdOk & idle & (b1 == sisp_pkg::OP_LOAD_HI);
    wire doLoadLo = cmdOk & idle & (b1 == sisp_pkg::OP_LOAD_LO);
    wire doPageWr = cmdOk & idle & (b1 == sisp_pkg::OP_PAGE_WRITE);
    wire doEeWr = cmdOk & idle & (b1 == sisp_pkg::OP_EE_WRITE);
    wire doEeLoad = cmdOk & idle & (b1 == sisp_pkg::OP_EE_LOAD);
    wire doEePgWr = cmdOk & idle & (b1 == sisp_pkg::OP_EE_PAGE_WRITE);
    wire doLockWr = cmdOk & idle & isAc & (b2 == sisp_pkg::SUB_LOCK);
    wire doFLoWr = cmdOk & idle & isAc & (b2 == sisp_pkg::SUB_FUSE_LO);
    wire doFHiWr = cmdOk & idle & isAc & (b2 == sisp_pkg::SUB_FUSE_HI);
    wire doFExWr = cmdOk & idle & isAc & (b2 == sisp_pkg::SUB_FUSE_EXT);
    wire doFuseAny = doLockWr | doFLoWr | doFHiWr | doFExWr;

    ////////////////////////////////////////////////////////////////////
    // Programming enable latch, cleared when the session ends
    // Enable on AC 53, drop on reset release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            progEnabled <= 1'b0;
        end else if (!inSession) begin
            progEnabled <= 1'b0;
        end else if (doEnable) begin
            progEnabled <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Busy timer; commits land at the start so reads see new data
    // Self-timed write, busy flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= sisp_pkg::ST_IDLE;
            busyCnt <= '0;
        end else begin
            case (state)
                sisp_pkg::ST_IDLE: begin
                    if (doErase) begin
                        state <= sisp_pkg::ST_ERASE;
                        busyCnt <= sisp_pkg::BUSY_W'(ERASE_WAIT - 1);
                    end else if (doPageWr) begin
                        state <= sisp_pkg::ST_BUSY;
                        busyCnt <= sisp_pkg::BUSY_W'(FLASH_WAIT - 1);
                    end else if (doEeWr | doEePgWr) begin
                        state <= sisp_pkg::ST_BUSY;
                        busyCnt <= sisp_pkg::BUSY_W'(EEPROM_WAIT - 1);
                    end else if (doFuseAny) begin
                        state <= sisp_pkg::ST_BUSY;
                        busyCnt <= sisp_pkg::BUSY_W'(FUSE_WAIT - 1);
                    end
                end
                default: begin
                    if (busyCnt == '0) begin
                        state <= sisp_pkg::ST_IDLE;
                    end else begin
                        busyCnt <= busyCnt - 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opPendingFlag <= 1'b0;
        end else begin
            opPendingFlag <= ~idle | doErase | doPageWr | doEeWr
                | doEePgWr | doFuseAny;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flash page buffer and array, one generate slot per word
    // Low then high byte into buffer slot
    // Page from high bits, offset ignored
    // Erase sets every word to ones
    genvar gi;
    for (gi = 0; gi < sisp_pkg::FLASH_WORDS; gi++) begin : gFlash
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                flashMem[gi] <= {sisp_pkg::ERASED, sisp_pkg::ERASED};
            end else if (doErase) begin
                flashMem[gi] <= {sisp_pkg::ERASED, sisp_pkg::ERASED};
            end else if (doPageWr && pageNum == gi / 32) begin
                flashMem[gi] <= pageBuf[gi % 32];
            end
        end
    end

    for (gi = 0; gi < 2**sisp_pkg::PAGE_AW; gi++) begin : gPage
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                pageBuf[gi] <= {sisp_pkg::ERASED, sisp_pkg::ERASED};
            end else if (doLoadLo && pageIdx == gi) begin
                pageBuf[gi][7:0] <= b4;
            end else if (doLoadHi && pageIdx == gi) begin
                pageBuf[gi][15:8] <= b4;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // EEPROM array; byte write replaces whole byte (auto-erase)
    // EEPROM writes
    for (gi = 0; gi < 2**sisp_pkg::EE_AW; gi++) begin : gEe
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                eeMem[gi] <= sisp_pkg::ERASED;
            end else if (doErase) begin
                eeMem[gi] <= sisp_pkg::ERASED;
            end else if (doEeWr && eeAddr == gi) begin
                eeMem[gi] <= b4;
            end else if (doEePgWr && eePage == gi / 4 && eeLoaded[gi % 4]) begin
                eeMem[gi] <= eeBuf[gi % 4];
            end
        end
    end

    // EEPROM buffer with per-byte loaded marks, cleared by page write
    for (gi = 0; gi < 2**sisp_pkg::EE_PAGE_AW; gi++) begin : gEeBuf
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                eeBuf[gi] <= sisp_pkg::ERASED;
                eeLoaded[gi] <= 1'b0;
            end else if (doEeLoad && b3[1:0] == gi) begin
                eeBuf[gi] <= b4;
                eeLoaded[gi] <= 1'b1;
            end else if (doEePgWr) begin
                eeLoaded[gi] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fuse and lock bytes; erase sets lock bits only, to all ones
    // Writes take byte four
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fuseLo <= sisp_pkg::FUSE_LO_RST;
            fuseHi <= sisp_pkg::FUSE_HI_RST;
            fuseExt <= sisp_pkg::FUSE_EXT_RST;
            lockBits <= sisp_pkg::LOCK_RST;
        end else begin
            if (doFLoWr) fuseLo <= b4;
            if (doFHiWr) fuseHi <= b4;
            if (doFExWr) fuseExt <= b4;
            if (doLockWr) lockBits <= b4;
            if (doErase) lockBits <= sisp_pkg::ERASED;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data select, decided once byte three is in
    // Read decode
    wire byte3Done = sckRise & (bitCnt == 5'h17);
    wire [7:0] c1 = shiftIn[22:15];
    wire [7:0] c2 = shiftIn[14:7];
    wire [7:0] c3 = {shiftIn[6:0], mosi};
    wire [sisp_pkg::FLASH_AW-1:0] rdAddr = sisp_pkg::FLASH_AW'({c2, c3});
    wire [7:0] sigByte = (c3[1:0] == 2'h0) ? sisp_pkg::SIG0 :
        (c3[1:0] == 2'h1) ? sisp_pkg::SIG1 : sisp_pkg::SIG2;
    wire [7:0] rdData =
        (c1 == sisp_pkg::OP_POLL) ? {7'h0, opPendingFlag} :
        !progEnabled ? 8'h00 :
        (c1 == sisp_pkg::OP_READ_HI) ? flashMem[rdAddr][15:8] :
        (c1 == sisp_pkg::OP_READ_LO) ? flashMem[rdAddr][7:0] :
        (c1 == sisp_pkg::OP_EE_READ) ? eeMem[c3[sisp_pkg::EE_AW-1:0]] :
        (c1 == sisp_pkg::OP_READ_LOCK_FHI && c2 == sisp_pkg::SEL_HIGH) ?
            fuseHi :
        (c1 == sisp_pkg::OP_READ_LOCK_FHI) ? lockBits :
        (c1 == sisp_pkg::OP_READ_FUSE && c2 == sisp_pkg::SEL_HIGH) ?
            fuseExt :
        (c1 == sisp_pkg::OP_READ_FUSE) ? fuseLo :
        (c1 == sisp_pkg::OP_READ_SIG) ? sigByte :
        (c1 == sisp_pkg::OP_READ_CAL) ? sisp_pkg::CAL_RST : 8'h00;

    // Out byte: echo byte two after byte two, read data after byte three
    wire byte2Done = sckRise & (bitCnt == 5'h0F);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outByte <= 8'h00;
        end else if (byte2Done) begin
            // Echo byte two during byte three
            outByte <= shiftIn[6:0] == 7'h0 && mosi == 1'b0 ?
                8'h00 : {shiftIn[6:0], mosi};
        end else if (byte3Done) begin
            outByte <= rdData;
        end else if (sckFall) begin
            outByte <= {outByte[6:0], 1'b0};
        end
    end

    // Output bit changes on falling edge only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serialOut <= 1'b0;
            serialOutEn <= 1'b0;
        end else begin
            serialOutEn <= inSession;
            if (sckFall) serialOut <= outByte[7];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    // Output holds unless the link clock falls
    out_on_fall_a: assert property (@(posedge clk) disable iff (rst)
        !sckFall |=> $stable(serialOut))
        else $error("serial out changed off a falling edge");
    // Watches the busy output, so a leak in the enable gate shows up
    enable_gate_a: assert property (@(posedge clk) disable iff (rst)
        (!progEnabled && idle) |=> !opPendingFlag)
        else $error("write accepted before enable");
    session_end_a: assert property (@(posedge clk) disable iff (rst)
        !inSession |=> !progEnabled)
        else $error("enable survived session end");
    busy_set_a: assert property (@(posedge clk) disable iff (rst)
        (doPageWr | doErase | doEeWr) |=> opPendingFlag [*2])
        else $error("busy not raised after write");
    erase_ones_a: assert property (@(posedge clk) disable iff (rst)
        doErase |=> eeMem[0] == sisp_pkg::ERASED && lockBits == 8'hFF)
        else $error("erase did not fill ones");
    ee_byte_a: assert property (@(posedge clk) disable iff (rst)
        doEeWr |=> eeMem[$past(eeAddr)] == $past(b4))
        else $error("eeprom byte write wrong");
    enable_set_a: assert property (@(posedge clk) disable iff (rst)
        (doEnable && inSession) |=> progEnabled)
        else $error("enable not taken");
    bit_count_a: assert property (@(posedge clk) disable iff (rst)
        lastBit |=> bitCnt == 5'h0)
        else $error("bit counter not 32");
    fuse_wr_a: assert property (@(posedge clk) disable iff (rst)
        doFLoWr |=> fuseLo == $past(b4))
        else $error("low fuse write wrong");

    enable_seen_c: cover property (@(posedge clk) doEnable);
    erase_seen_c: cover property (@(posedge clk) doErase);
    page_seen_c: cover property (@(posedge clk) doPageWr);
    read_seen_c: cover property (@(posedge clk) byte3Done && progEnabled);
endmodule
`default_nettype wire

// *** test/sisp_programmer.sv ***
// Behavioural serial programmer that drives the in-system programming link
`timescale 1ns/1ps
`default_nettype none
module sisp_programmer #(
    parameter int POWER_WAIT = 40
) (
    input wire logic clk,
    input wire logic serialOut,
    output var logic resetPinN,
    output var logic serialClk,
    output var logic serialIn
);
    ////////////////////////////////////////////////////////////////////////
    // power-up levels
    // Reset pin and link clock both low from time zero
    initial begin
        resetPinN = 1'b0;
        serialClk = 1'b0;
        serialIn = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // settle before enable
    // Stands in for the long settle time, shortened to keep runs brief
    task automatic power_up();
        repeat (POWER_WAIT) @(posedge clk);
    endtask

    // whole instructions
    // Always 32 bits MSB first; reply bit read as the clock rises
    task automatic xfer(input logic [31:0] inst, output logic [31:0] resp);
        resp = 32'h0;
        for (int i = 31; i >= 0; i--) begin
            @(posedge clk);
            serialClk <= 1'b0;
            serialIn <= inst[i];
            // phase lengths
            // Low 12 clk, high 13 clk: a 125 ns link period
            repeat (12) @(posedge clk);
            resp[i] = serialOut;
            serialClk <= 1'b1;
            repeat (12) @(posedge clk);
        end
        @(posedge clk);
        serialClk <= 1'b0;
        serialIn <= ~inst[0];  // Idle data is not left at the last bit
    endtask

    ////////////////////////////////////////////////////////////////////////
    // resync pulse
    // Reset high for four clocks with the link clock held low
    task automatic pulse_reset();
        @(posedge clk);
        resetPinN <= 1'b1;
        repeat (4) @(posedge clk);
        resetPinN <= 1'b0;
        repeat (POWER_WAIT) @(posedge clk);
    endtask

    // stray clock pulse
    // One extra link clock knocks the bit count out of step
    task automatic stray_edge();
        @(posedge clk);
        serialClk <= 1'b1;
        repeat (12) @(posedge clk);
        serialClk <= 1'b0;
        repeat (12) @(posedge clk);
    endtask

    task automatic end_session();
        @(posedge clk);
        resetPinN <= 1'b1;
        repeat (10) @(posedge clk);
    endtask

    task automatic start_session();
        @(posedge clk);
        resetPinN <= 1'b0;
        repeat (POWER_WAIT) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** test/sisp_tb.sv ***
// Self-checking testbench for the serial in-system programming port
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    wire logic resetPinN, serialClk, serialIn, serialOut;
    wire logic serialOutEn, progEnabled, opPendingFlag;
    int failures = 0;
    int nTests = 0;
    logic [31:0] r;

    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // Waits kept longer than one instruction so busy shows on the first poll
    sisp_port #(.FLASH_WAIT(1000), .EEPROM_WAIT(900), .ERASE_WAIT(1000),
        .FUSE_WAIT(900)) DUT (.clk(clk), .rst(rst), .resetPinN(resetPinN),
        .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .progEnabled(progEnabled),
        .opPendingFlag(opPendingFlag));

    sisp_programmer #(.POWER_WAIT(40)) prog (.clk(clk),
        .serialOut(serialOut), .resetPinN(resetPinN),
        .serialClk(serialClk), .serialIn(serialIn));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk8(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        nTests++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic cmd(input logic [7:0] b1, input logic [7:0] b2,
        input logic [7:0] b3, input logic [7:0] b4);
        prog.xfer({b1, b2, b3, b4}, r);
    endtask

    // First poll must still see busy, then it must clear within a few polls
    task automatic poll_done();
        cmd(8'hF0, 8'h00, 8'h00, 8'h00);
        chk1("busy on first poll", 1'b1, r[0]);
        for (int i = 0; i < 4 && r[0] !== 1'b0; i++)
            cmd(8'hF0, 8'h00, 8'h00, 8'h00);
        chk1("busy cleared", 1'b0, r[0]);
    endtask

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_before();
        cmd(8'hA0, 8'h00, 8'h05, 8'h00);
        chk8("read before enable", 8'h00, r[7:0]);
        cmd(8'hAC, 8'h80, 8'h00, 8'h00);
        chk1("erase refused", 1'b0, opPendingFlag);
        chk1("not enabled", 1'b0, progEnabled);
    endtask

    task automatic t_enable();
        chk1("output enable", 1'b1, serialOutEn);
        cmd(8'hAC, 8'h53, 8'h00, 8'h00);
        chk8("enable echo", 8'h53, r[15:8]);
        chk1("enabled", 1'b1, progEnabled);
    endtask

    // Dirty one flash and one EEPROM byte so the erase has work to do
    task automatic t_erase();
        cmd(8'hC0, 8'h00, 8'h3F, 8'h00);
        poll_done();
        cmd(8'h40, 8'h07, 8'hFF, 8'h00);
        cmd(8'h4C, 8'h07, 8'hFF, 8'h00);
        poll_done();
        cmd(8'hAC, 8'h80, 8'h00, 8'h00);
        chk1("erase busy", 1'b1, opPendingFlag);
        poll_done();
        cmd(8'h20, 8'h07, 8'hFF, 8'h00);
        chk8("flash top low", 8'hFF, r[7:0]);
        cmd(8'h28, 8'h00, 8'h00, 8'h00);
        chk8("flash first high", 8'hFF, r[7:0]);
        cmd(8'hA0, 8'h00, 8'h3F, 8'h00);
        chk8("eeprom top", 8'hFF, r[7:0]);
    endtask

    // Page 3, slots 0 and 31; commit with a mid-page address
    task automatic t_flash();
        cmd(8'h40, 8'h00, 8'h60, 8'h12);
        cmd(8'h48, 8'h00, 8'h60, 8'h34);
        cmd(8'h40, 8'h00, 8'h7F, 8'h56);
        cmd(8'h48, 8'h00, 8'h7F, 8'h78);
        cmd(8'h4C, 8'h00, 8'h67, 8'h00);
        chk1("page write busy", 1'b1, opPendingFlag);
        poll_done();
        cmd(8'h20, 8'h00, 8'h60, 8'h00);
        chk8("slot0 low", 8'h12, r[7:0]);
        cmd(8'h28, 8'h00, 8'h60, 8'h00);
        chk8("slot0 high", 8'h34, r[7:0]);
        cmd(8'h20, 8'h00, 8'h7F, 8'h00);
        chk8("slot31 low", 8'h56, r[7:0]);
        cmd(8'h28, 8'h00, 8'h7F, 8'h00);
        chk8("slot31 high", 8'h78, r[7:0]);
        cmd(8'h20, 8'h00, 8'h80, 8'h00);
        chk8("next page untouched", 8'hFF, r[7:0]);
    endtask

    // Second write sets bits the first cleared: only an erase gets there
    task automatic t_eeprom();
        cmd(8'hC0, 8'h00, 8'h05, 8'h3C);
        chk1("eeprom busy", 1'b1, opPendingFlag);
        poll_done();
        cmd(8'hC0, 8'h00, 8'h05, 8'hC3);
        poll_done();
        cmd(8'hC0, 8'h00, 8'h04, 8'h5A);
        poll_done();
        cmd(8'hA0, 8'h00, 8'h05, 8'h00);
        chk8("eeprom auto erase", 8'hC3, r[7:0]);
        cmd(8'hC1, 8'h00, 8'h01, 8'h77);
        cmd(8'hC2, 8'h00, 8'h04, 8'h00);
        poll_done();
        cmd(8'hA0, 8'h00, 8'h05, 8'h00);
        chk8("eeprom page slot", 8'h77, r[7:0]);
        cmd(8'hA0, 8'h00, 8'h04, 8'h00);
        chk8("unloaded slot 0", 8'h5A, r[7:0]);
        cmd(8'hA0, 8'h00, 8'h06, 8'h00);
        chk8("unloaded slot 2", 8'hFF, r[7:0]);
    endtask

    // Low, high, extended fuse then lock; lock last so nothing else blocks
    task automatic t_fuse();
        logic [7:0] rd1 [4] = '{8'h50, 8'h58, 8'h50, 8'h58};
        logic [7:0] rd2 [4] = '{8'h00, 8'h08, 8'h08, 8'h00};
        logic [7:0] wr2 [4] = '{8'hA0, 8'hA8, 8'hA4, 8'hE0};
        logic [7:0] nv [4] = '{8'h3E, 8'hD7, 8'hFE, 8'hFC};
        logic [7:0] dv [4] = '{sisp_pkg::FUSE_LO_RST, sisp_pkg::FUSE_HI_RST,
            sisp_pkg::FUSE_EXT_RST, sisp_pkg::LOCK_RST};
        logic [7:0] sg [3] = '{sisp_pkg::SIG0, sisp_pkg::SIG1, sisp_pkg::SIG2};
        for (int i = 0; i < 4; i++) begin
            cmd(rd1[i], rd2[i], 8'h00, 8'h00);
            chk8("fuse default", dv[i], r[7:0]);
            cmd(8'hAC, wr2[i], 8'h00, nv[i]);
            poll_done();
            cmd(rd1[i], rd2[i], 8'h00, 8'h00);
            chk8("fuse written", nv[i], r[7:0]);
        end
        for (int i = 0; i < 3; i++) begin
            cmd(8'h30, 8'h00, 8'(i), 8'h00);
            chk8("signature", sg[i], r[7:0]);
        end
        cmd(8'h38, 8'h00, 8'h00, 8'h00);
        chk8("calibration", sisp_pkg::CAL_RST, r[7:0]);
    endtask

    task automatic t_resync();
        prog.end_session();
        chk1("output released", 1'b0, serialOutEn);
        prog.start_session();
        chk1("enable needed again", 1'b0, progEnabled);
        prog.stray_edge();
        cmd(8'hAC, 8'h53, 8'h00, 8'h00);
        chk1("no enable out of step", 1'b0, progEnabled);
        prog.pulse_reset();
        cmd(8'hAC, 8'h53, 8'h00, 8'h00);
        chk8("echo after pulse", 8'h53, r[15:8]);
        chk1("enabled again", 1'b1, progEnabled);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: about 57k clocks of traffic
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        prog.power_up();
        t_before();
        t_enable();
        t_erase();
        t_flash();
        t_eeprom();
        t_fuse();
        t_resync();
        end_of_test();
    end

    // Watchdog well past the expected run length
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        $display("Error watchdog expected finish seen hang");
        end_of_test();
    end
endmodule
`default_nettype wire
